// ---- logic/display_field_pkg.sv ----
// Constants for the display field bit, vertical interrupt and default value block.
package display_field_pkg;
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFS_DEFAULT_VALUE = 5'h00;
   localparam logic [4:0] OFS_VERT_IRQ = 5'h04;
   localparam logic [4:0] OFS_FIELD_BIT = 5'h08;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
   localparam logic [4:0] OFS_LINE_STATUS = 5'h14;
   localparam logic [31:0] MASK_DEFAULT_VALUE = 32'hFFFF_00FF;
   localparam logic [31:0] MASK_VERT_IRQ = 32'h8FFF_8FFF;
   localparam logic [31:0] MASK_FIELD_BIT = 32'h0FFF_0FFF;
   localparam logic [31:0] MASK_IRQ = 32'h0000_0003;
   localparam logic [31:0] RESET_REG = 32'h0000_0000;
   localparam int CR_MSB = 31;
   localparam int CR_LSB = 24;
   localparam int CB_MSB = 23;
   localparam int CB_LSB = 16;
   localparam int Y_MSB = 7;
   localparam int Y_LSB = 0;
   localparam int F2_EN_BIT = 31;
   localparam int F1_EN_BIT = 15;
   localparam int HI_LINE_MSB = 27;
   localparam int HI_LINE_LSB = 16;
   localparam int LO_LINE_MSB = 11;
   localparam int LO_LINE_LSB = 0;
   localparam int LINE_W = 12;
   localparam int LANE_W = 10;
   localparam int IRQ_F1_BIT = 0;
   localparam int IRQ_F2_BIT = 1;
   localparam int STAT_FBIT_BIT = 16;
   localparam logic [11:0] FIRST_LINE = 12'h001;
   localparam logic [1:0] LANE_LSB_ZERO = 2'h0;
endpackage : display_field_pkg

// ---- logic/display_field_timing.sv ----
// Field bit generation, per-field vertical interrupt and default display values with an Avalon-MM slave.
`timescale 1ns/10ps

// Overview of operation
// - Cb default from bits 23-16.
// - Y default from bits 7-0.
// - Reserved bits read zero, writes ignored.
// - Interrupt when line counter equals programmed line.
// - Per-field enables, bit 31 and 15.
// - Interrupt lines in 27-16 and 11-0.
// - F cleared at EAV of field-1 line.
// - F set at EAV of field-2 line.
// - F independent of field indicator output.
// - Field bit lines 27-16 and 11-0, rest zero.
// - Defaults on upper eight lane bits, LSBs zero.
module display_field_timing
   import display_field_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic line_start,
   input wire logic frame_start,
   input wire logic chroma_sel,
   output logic field_bit,
   output logic [LINE_W-1:0] frame_line_counter,
   output logic [LANE_W-1:0] luma_lane,
   output logic [LANE_W-1:0] chroma_lane,
   output logic vertical_interrupt
);

   logic [31:0] default_value_q;
   logic [31:0] vert_irq_q;
   logic [31:0] field_bit_lines_q;
   logic [1:0] irq_status_q;
   logic [1:0] irq_mask_q;
   logic [LINE_W-1:0] line_cnt_q;
   logic [LINE_W-1:0] line_cnt_d;
   logic f_bit_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [LANE_W-1:0] luma_q;
   logic [LANE_W-1:0] chroma_q;
   logic irq_q;
   logic access_done;
   logic [1:0] irq_event;
   logic [1:0] irq_clear;

   // Merges the enabled byte lanes of a write and forces reserved bits to zero.
   function automatic logic [31:0] merge_write(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be, input logic [31:0] keep);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r & keep;
   endfunction : merge_write

   // A transfer completes on the edge where the slave shows waitrequest low.
   assign access_done = (read || write) && !wait_q;

   // One wait state on every access so read data can come from a flip-flop.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
      end else if ((read || write) && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= RESET_REG;
      end else if (read && wait_q) begin
         unique case (address)
            OFS_DEFAULT_VALUE: rdata_q <= default_value_q & MASK_DEFAULT_VALUE;
            OFS_VERT_IRQ: rdata_q <= vert_irq_q & MASK_VERT_IRQ;
            OFS_FIELD_BIT: rdata_q <= field_bit_lines_q & MASK_FIELD_BIT;
            OFS_IRQ_STATUS: rdata_q <= {30'h0, irq_status_q};
            OFS_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
            OFS_LINE_STATUS: rdata_q <= {15'h0, f_bit_q, 4'h0, line_cnt_q};
            default: rdata_q <= RESET_REG;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         default_value_q <= RESET_REG;
         vert_irq_q <= RESET_REG;
         field_bit_lines_q <= RESET_REG;
         irq_mask_q <= 2'h0;
      end else if (access_done && write) begin
         unique case (address)
            OFS_DEFAULT_VALUE: default_value_q <= merge_write(default_value_q, writedata, byteenable,
                                                              MASK_DEFAULT_VALUE);
            OFS_VERT_IRQ: vert_irq_q <= merge_write(vert_irq_q, writedata, byteenable, MASK_VERT_IRQ);
            OFS_FIELD_BIT: field_bit_lines_q <= merge_write(field_bit_lines_q, writedata, byteenable,
                                                            MASK_FIELD_BIT);
            OFS_IRQ_MASK: irq_mask_q <= 2'(merge_write({30'h0, irq_mask_q}, writedata, byteenable,
                                                       MASK_IRQ));
            default: irq_mask_q <= irq_mask_q;
         endcase
      end
   end

   // The counter starts each frame at line one and steps at every line start.
   always_comb begin
      if (frame_start) begin
         line_cnt_d = FIRST_LINE;
      end else if (line_start) begin
         line_cnt_d = line_cnt_q + FIRST_LINE;
      end else begin
         line_cnt_d = line_cnt_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         line_cnt_q <= '0;
      end else begin
         line_cnt_q <= line_cnt_d;
      end
   end

   // F changes only at the EAV of a line start; the field indicator output plays no part here.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         f_bit_q <= 1'b0;
      end else if (frame_start || line_start) begin
         if (line_cnt_d == field_bit_lines_q[LO_LINE_MSB:LO_LINE_LSB]) begin
            f_bit_q <= 1'b0;
         end else if (line_cnt_d == field_bit_lines_q[HI_LINE_MSB:HI_LINE_LSB]) begin
            f_bit_q <= 1'b1;
         end
      end
   end

   // A line is finished when the next one starts, so the match is on the count still held.
   assign irq_event[IRQ_F1_BIT] = (line_start || frame_start) && vert_irq_q[F1_EN_BIT] &&
                                  (line_cnt_q == vert_irq_q[LO_LINE_MSB:LO_LINE_LSB]);
   assign irq_event[IRQ_F2_BIT] = (line_start || frame_start) && vert_irq_q[F2_EN_BIT] &&
                                  (line_cnt_q == vert_irq_q[HI_LINE_MSB:HI_LINE_LSB]);
   assign irq_clear = (access_done && write && address == OFS_IRQ_STATUS && byteenable[0]) ?
                      writedata[1:0] : 2'h0;

   // A new event in the clearing cycle wins so it is never lost.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_status_q <= 2'h0;
      end else begin
         irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(((irq_status_q & ~irq_clear) | irq_event) & irq_mask_q);
      end
   end

   // Lanes carry the eight stored bits on top; the two fraction bits are always zero.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         luma_q <= '0;
         chroma_q <= '0;
      end else begin
         luma_q <= {default_value_q[Y_MSB:Y_LSB], LANE_LSB_ZERO};
         chroma_q <= chroma_sel ? {default_value_q[CR_MSB:CR_LSB], LANE_LSB_ZERO} :
                                  {default_value_q[CB_MSB:CB_LSB], LANE_LSB_ZERO};
      end
   end

   assign readdata = rdata_q;
   assign waitrequest = wait_q;
   assign field_bit = f_bit_q;
   assign frame_line_counter = line_cnt_q;
   assign luma_lane = luma_q;
   assign chroma_lane = chroma_q;
   assign vertical_interrupt = irq_q;

   a_fbit_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      (line_start || frame_start) && line_cnt_d == field_bit_lines_q[11:0] |=> !f_bit_q)
      else $error("F bit not cleared at field 1 line.");
   a_fbit_set: assert property (@(posedge mclk) disable iff (!rst_n)
      (line_start || frame_start) && line_cnt_d == field_bit_lines_q[27:16] &&
      line_cnt_d != field_bit_lines_q[11:0] |=> f_bit_q)
      else $error("F bit not set at field 2 line.");
   a_fbit_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !(line_start || frame_start) |=> $stable(f_bit_q))
      else $error("F bit changed away from a line start.");
   a_irq_field1: assert property (@(posedge mclk) disable iff (!rst_n)
      line_start && vert_irq_q[15] && line_cnt_q == vert_irq_q[11:0] |=> irq_status_q[0])
      else $error("Field 1 interrupt not flagged.");
   a_irq_field2_off: assert property (@(posedge mclk) disable iff (!rst_n)
      !irq_status_q[1] && !vert_irq_q[31] |=> !irq_status_q[1])
      else $error("Disabled field 2 interrupt flagged.");
   a_irq_output: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 vertical_interrupt == |(irq_status_q & $past(irq_mask_q)))
      else $error("Interrupt output did not follow status.");
   a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      (default_value_q & ~MASK_DEFAULT_VALUE) == 32'h0 && (vert_irq_q & ~MASK_VERT_IRQ) == 32'h0 &&
      (field_bit_lines_q & ~MASK_FIELD_BIT) == 32'h0)
      else $error("Reserved bit held a one.");
   a_lane_lsbs: assert property (@(posedge mclk) disable iff (!rst_n)
      luma_lane[1:0] == 2'h0 && chroma_lane[1:0] == 2'h0)
      else $error("Lane low bits not zero.");
   a_luma_value: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 luma_lane[9:2] == $past(default_value_q[7:0]))
      else $error("Luma lane does not carry default.");
   a_line_restart: assert property (@(posedge mclk) disable iff (!rst_n)
      frame_start |=> line_cnt_q == 12'h001)
      else $error("Line counter did not restart.");
   a_bus_answer: assert property (@(posedge mclk) disable iff (!rst_n)
      (read || write) && waitrequest |=> !waitrequest)
      else $error("Bus answer not after one wait state.");

   a_fbit_no_rise: assert property (@(posedge mclk) disable iff (!rst_n)
      (line_start || frame_start) && !f_bit_q &&
      line_cnt_d != field_bit_lines_q[HI_LINE_MSB:HI_LINE_LSB]
      |=> !f_bit_q)
      else $error("F bit rose away from the field 2 line.");
   a_fbit_no_fall: assert property (@(posedge mclk) disable iff (!rst_n)
      (line_start || frame_start) && f_bit_q &&
      line_cnt_d != field_bit_lines_q[LO_LINE_MSB:LO_LINE_LSB]
      |=> f_bit_q)
      else $error("F bit fell away from the field 1 line.");

   a_irq_field2: assert property (@(posedge mclk) disable iff (!rst_n)
      line_start && vert_irq_q[F2_EN_BIT] &&
      line_cnt_q == vert_irq_q[HI_LINE_MSB:HI_LINE_LSB]
      |=> irq_status_q[IRQ_F2_BIT])
      else $error("Field 2 interrupt not flagged.");
   a_irq_field1_off: assert property (@(posedge mclk) disable iff (!rst_n)
      !irq_status_q[IRQ_F1_BIT] && !vert_irq_q[F1_EN_BIT]
      |=> !irq_status_q[IRQ_F1_BIT])
      else $error("Disabled field 1 interrupt flagged.");
   a_set_wins_f1: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_event[IRQ_F1_BIT]
      |=> irq_status_q[IRQ_F1_BIT])
      else $error("Field 1 event lost.");
   a_set_wins_f2: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_event[IRQ_F2_BIT]
      |=> irq_status_q[IRQ_F2_BIT])
      else $error("Field 2 event lost.");
   a_quiet_f1: assert property (@(posedge mclk) disable iff (!rst_n)
      !(line_start || frame_start) && !irq_status_q[IRQ_F1_BIT]
      |=> !irq_status_q[IRQ_F1_BIT])
      else $error("Field 1 flag set away from a line start.");
   a_quiet_f2: assert property (@(posedge mclk) disable iff (!rst_n)
      !(line_start || frame_start) && !irq_status_q[IRQ_F2_BIT]
      |=> !irq_status_q[IRQ_F2_BIT])
      else $error("Field 2 flag set away from a line start.");
   a_clear_f1: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_clear[IRQ_F1_BIT] && !irq_event[IRQ_F1_BIT]
      |=> !irq_status_q[IRQ_F1_BIT])
      else $error("Field 1 flag not cleared.");
   a_clear_f2: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_clear[IRQ_F2_BIT] && !irq_event[IRQ_F2_BIT]
      |=> !irq_status_q[IRQ_F2_BIT])
      else $error("Field 2 flag not cleared.");
   a_irq_masked: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_mask_q == 2'h0
      |=> !vertical_interrupt)
      else $error("Interrupt raised with every source masked.");
   a_irq_flag_out: assert property (@(posedge mclk) disable iff (!rst_n)
      vertical_interrupt
      |-> |irq_status_q)
      else $error("Interrupt high with no flag set.");

   a_cb_value: assert property (@(posedge mclk) disable iff (!rst_n)
      !chroma_sel
      |=> chroma_lane[9:2] == $past(default_value_q[CB_MSB:CB_LSB]))
      else $error("Chroma lane does not carry the Cb default.");
   a_cr_value: assert property (@(posedge mclk) disable iff (!rst_n)
      chroma_sel
      |=> chroma_lane[9:2] == $past(default_value_q[CR_MSB:CR_LSB]))
      else $error("Chroma lane does not carry the Cr default.");
   a_line_step: assert property (@(posedge mclk) disable iff (!rst_n)
      line_start && !frame_start
      |=> line_cnt_q == $past(line_cnt_q) + 12'h001)
      else $error("Line counter did not step.");
   a_line_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !line_start && !frame_start
      |=> $stable(line_cnt_q))
      else $error("Line counter moved between lines.");

   a_bus_one_low: assert property (@(posedge mclk) disable iff (!rst_n)
      !waitrequest
      |=> waitrequest)
      else $error("Bus answer stood longer than one cycle.");
   a_bus_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      !read && !write
      |=> waitrequest)
      else $error("Bus answered with no request.");
   a_cfg_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !(write && !waitrequest)
      |=> $stable(default_value_q) && $stable(vert_irq_q) && $stable(field_bit_lines_q))
      else $error("Setting changed without a completed write.");
   a_rd_default: assert property (@(posedge mclk) disable iff (!rst_n)
      read && !waitrequest && address == OFS_DEFAULT_VALUE
      |-> (readdata & ~MASK_DEFAULT_VALUE) == 32'h0)
      else $error("Default value read showed a reserved one.");
   a_rd_vert_irq: assert property (@(posedge mclk) disable iff (!rst_n)
      read && !waitrequest && address == OFS_VERT_IRQ
      |-> (readdata & ~MASK_VERT_IRQ) == 32'h0)
      else $error("Vertical interrupt read showed a reserved one.");
   a_rd_field_bit: assert property (@(posedge mclk) disable iff (!rst_n)
      read && !waitrequest && address == OFS_FIELD_BIT
      |-> (readdata & ~MASK_FIELD_BIT) == 32'h0)
      else $error("Field bit read showed a reserved one.");
   a_rd_irq_regs: assert property (@(posedge mclk) disable iff (!rst_n)
      read && !waitrequest && (address == OFS_IRQ_STATUS || address == OFS_IRQ_MASK)
      |-> (readdata & ~MASK_IRQ) == 32'h0)
      else $error("Interrupt register read showed a reserved one.");
   a_rd_line_status: assert property (@(posedge mclk) disable iff (!rst_n)
      read && !waitrequest && address == OFS_LINE_STATUS
      |-> readdata[LINE_W-1:0] == $past(line_cnt_q) && readdata[STAT_FBIT_BIT] == $past(f_bit_q))
      else $error("Line status read does not match the counter.");
   a_rd_unmapped: assert property (@(posedge mclk) disable iff (!rst_n)
      read && !waitrequest && address > OFS_LINE_STATUS
      |-> readdata == 32'h0)
      else $error("Unmapped read returned data.");

   c_field_change: cover property (@(posedge mclk) disable iff (!rst_n) !f_bit_q ##1 f_bit_q);
   c_irq_raised: cover property (@(posedge mclk) disable iff (!rst_n) !vertical_interrupt ##1 vertical_interrupt);
   c_clear_race: cover property (@(posedge mclk) disable iff (!rst_n) |(irq_clear & irq_event));
   c_field_clear: cover property (@(posedge mclk) disable iff (!rst_n) f_bit_q ##1 !f_bit_q);
   c_both_pending: cover property (@(posedge mclk) disable iff (!rst_n) irq_status_q == 2'h3);
endmodule : display_field_timing

// ---- tb/video_sink_model.sv ----
// Model of the video sink that paces output lines and samples the F bit of each timing code.
`timescale 1ns/10ps
module video_sink_model (
   input wire logic mclk,
   input wire logic field_bit,
   output logic line_start,
   output logic frame_start,
   output logic f_seen
);
   initial begin
      line_start = 1'b0;
      frame_start = 1'b0;
      f_seen = 1'b0;
   end
   // One line boundary; the F bit is taken once the code that opens the new line has settled.
   task automatic next_line(input logic first);
      begin
         frame_start <= first;
         line_start <= ~first;
         @(posedge mclk);
         line_start <= 1'b0;
         frame_start <= 1'b0;
         @(posedge mclk);
         f_seen = field_bit;
      end
   endtask : next_line
endmodule : video_sink_model

// ---- tb/display_field_bit_and_vertical_interrupt_control_test.sv ----
// Self-checking bench for the field bit, vertical interrupt and default value block.
`timescale 1ns/10ps
module display_field_bit_and_vertical_interrupt_control_test;
   import display_field_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = '0;
   logic chroma_sel = 1'b0;
   logic [31:0] readdata;
   logic waitrequest;
   logic field_bit;
   logic [LINE_W-1:0] frame_line_counter;
   logic [LANE_W-1:0] luma_lane;
   logic [LANE_W-1:0] chroma_lane;
   logic vertical_interrupt;
   logic line_start;
   logic frame_start;
   logic f_seen;
   logic f_exp;
   logic [31:0] q;
   logic [4:0] ofs [3] = '{OFS_DEFAULT_VALUE, OFS_VERT_IRQ, OFS_FIELD_BIT};
   logic [31:0] msk [3] = '{MASK_DEFAULT_VALUE, MASK_VERT_IRQ, MASK_FIELD_BIT};
   int n_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   display_field_timing i_dut (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .line_start(line_start), .frame_start(frame_start), .chroma_sel(chroma_sel), .field_bit(field_bit),
      .frame_line_counter(frame_line_counter), .luma_lane(luma_lane), .chroma_lane(chroma_lane),
      .vertical_interrupt(vertical_interrupt));
   video_sink_model i_sink (.mclk(mclk), .field_bit(field_bit), .line_start(line_start),
      .frame_start(frame_start), .f_seen(f_seen));

   always #10 mclk = ~mclk;

   // The whole run needs well under a thousand cycles, so this ceiling only trips on a hang.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One bus access; a free edge follows so strobes never toggle twice in one step.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, exp);
   endtask : rd

   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 5; i++) rd(5'(i * 4), RESET_REG);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, ofs[i], 32'hFFFF_FFFF);
         rd(ofs[i], msk[i]);
      end
      rd(5'h18, 32'h0000_0000);
      bus(1'b1, OFS_DEFAULT_VALUE, 32'h1234_5678);
      rd(OFS_DEFAULT_VALUE, 32'h1234_0078);
      chk(32'(luma_lane), 32'({8'h78, LANE_LSB_ZERO}));
      chk(32'(chroma_lane), 32'({8'h34, LANE_LSB_ZERO}));
      chroma_sel <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(32'(chroma_lane), 32'({8'h12, LANE_LSB_ZERO}));
      bus(1'b1, OFS_VERT_IRQ, 32'h8006_8003);
      bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      // Field 1 starts at line 2 and field 2 at line 5, after the blanking lines end.
      bus(1'b1, OFS_FIELD_BIT, 32'h0005_0002);
      f_exp = 1'b0;
      for (int fr = 0; fr < 3; fr++) begin
         // The last frame is progressive: the field 2 line lies beyond the frame height.
         if (fr == 2) bus(1'b1, OFS_FIELD_BIT, 32'h0FFF_0002);
         for (int k = 1; k < 8; k++) begin
            i_sink.next_line(k == 1);
            if (k == 2) f_exp = 1'b0;
            else if (k == 5 && fr < 2) f_exp = 1'b1;
            chk(32'(f_seen), 32'(f_exp));
            chk(32'(frame_line_counter), 32'(k));
            if (fr == 0) chk(32'(vertical_interrupt), 32'(k >= 4));
         end
      end
      rd(OFS_LINE_STATUS, 32'h0000_0007);
      rd(OFS_IRQ_STATUS, 32'h0000_0003);
      bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
      @(posedge mclk);
      chk(32'(vertical_interrupt), 32'h0000_0000);
      rd(OFS_IRQ_STATUS, 32'h0000_0002);
      bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
      @(posedge mclk);
      chk(32'(vertical_interrupt), 32'h0000_0001);
      bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0002);
      bus(1'b1, OFS_VERT_IRQ, 32'h0006_0003);
      for (int k = 1; k < 8; k++) i_sink.next_line(k == 1);
      rd(OFS_IRQ_STATUS, 32'h0000_0000);
      chk(32'(vertical_interrupt), 32'h0000_0000);
      bus(1'b1, OFS_VERT_IRQ, 32'h0000_8007);
      // The clear lands on the very edge that ends line 7, so the new event must survive it.
      fork
         bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
         begin
            @(posedge mclk);
            i_sink.next_line(1'b0);
         end
      join
      rd(OFS_IRQ_STATUS, 32'h0000_0001);
      byteenable <= 4'hE;
      bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
      byteenable <= 4'hF;
      rd(OFS_IRQ_STATUS, 32'h0000_0001);
      byteenable <= 4'h4;
      bus(1'b1, OFS_DEFAULT_VALUE, 32'hAAAA_AAAA);
      byteenable <= 4'hF;
      rd(OFS_DEFAULT_VALUE, 32'h12AA_0078);
      print_verdict();
   end
endmodule : display_field_bit_and_vertical_interrupt_control_test
